// file: src/flash_regs_pkg.sv
// package: register map, field layout, reset values and load sequencer states of the flash control registers
package flash_regs_pkg;

   // -----------------------------------------------------------------
   // bus geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int IDX_W = 10;

   // -----------------------------------------------------------------
   // register indices; byte address is four times the index
   // -----------------------------------------------------------------
   localparam logic [IDX_W-1:0] DIVIDER_IDX = 10'h000;
   localparam logic [IDX_W-1:0] LOCK_STATUS_IDX = 10'h001;

   // -----------------------------------------------------------------
   // divider register fields
   // -----------------------------------------------------------------
   localparam int DIV_LOADED_BIT = 7;
   localparam int DIV_VALUE_MSB = 6;
   localparam int DIV_VALUE_W = 7;
   localparam logic [DIV_VALUE_W-1:0] DIV_VALUE_RESET = 7'h00;

   // -----------------------------------------------------------------
   // lock status register fields and codes
   // -----------------------------------------------------------------
   localparam int KEY_EN_MSB = 7;
   localparam int KEY_EN_LSB = 6;
   localparam int LOCK_MSB = 1;
   localparam int LOCK_LSB = 0;
   localparam logic [1:0] KEY_EN_ENABLED = 2'h2;
   localparam logic [1:0] LOCK_UNSECURED = 2'h2;
   localparam logic [REG_W-1:0] LOCK_RESET = 8'hFF;
   localparam logic [REG_W-1:0] LOCK_FAULT_VALUE = 8'hFF;

   // -----------------------------------------------------------------
   // nonvolatile security byte location
   // -----------------------------------------------------------------
   localparam int NV_ADDR_W = 23;
   localparam logic [NV_ADDR_W-1:0] NV_SECURITY_ADDR = 23'h7FFF0F;

   // -----------------------------------------------------------------
   // reset-time load sequencer
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {SEQ_REQUEST, SEQ_WAIT, SEQ_RUN} seq_state_t;

endpackage

// file: src/timing_clk_if.sv
// interface: divider setting in, timing clock tick out
`timescale 1ns/1ps
`default_nettype none
interface timing_clk_if;
   logic [flash_regs_pkg::DIV_VALUE_W-1:0] divValue;
   logic divLoaded;
   logic tick;
   logic level;

   modport gen (input divValue, input divLoaded, output tick, output level);
   modport ctl (output divValue, output divLoaded, input tick, input level);
endinterface
`default_nettype wire

// file: src/timing_clock_gen.sv
// module: divides the oscillator clock down to the timing clock
`timescale 1ns/1ps
`default_nettype none
module timing_clock_gen (
   input wire logic mclk,
   input wire logic reset_n,
   timing_clk_if.gen tc
);
   import flash_regs_pkg::*;

   logic [DIV_VALUE_W-1:0] count_r;
   logic tick_r;
   logic level_r;
   logic wrap;

   // period is divValue+1 oscillator cycles; band 0x01 at 2.10 MHz gives 1.05 MHz
   assign wrap = (count_r == tc.divValue);

   // -----------------------------------------------------------------
   // cycle counter; idle until the divider is loaded
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n || !tc.divLoaded) begin
         count_r <= '0;
      end else if (wrap) begin
         count_r <= '0;
      end else begin
         count_r <= count_r + 7'h01;
      end
   end

   // -----------------------------------------------------------------
   // one tick per timing clock period, level toggles per tick
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n || !tc.divLoaded) begin
         tick_r <= 1'b0;
         level_r <= 1'b0;
      end else begin
         tick_r <= wrap;
         level_r <= level_r ^ wrap;
      end
   end

   assign tc.tick = tick_r;
   assign tc.level = level_r;
endmodule // timing_clock_gen
`default_nettype wire

// file: src/flash_clock_div_and_security_regs.sv
// module: flash timing clock divider and lock status registers behind APB
// -----------------------------------------------------------------
// -----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module flash_clock_div_and_security_regs (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [flash_regs_pkg::ADDR_W-1:0] paddr,
   input wire logic [flash_regs_pkg::DATA_W-1:0] pwdata,
   output logic [flash_regs_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic nvReadReq,
   output logic [flash_regs_pkg::NV_ADDR_W-1:0] nvReadAddr,
   input wire logic nvReadValid,
   input wire logic [flash_regs_pkg::REG_W-1:0] nvReadData,
   input wire logic nvDoubleFault,
   input wire logic cmdActive,
   input wire logic backdoorUnsecure,
   output logic commandCompleteFlag,
   output logic timingClock,
   output logic timingTick,
   output logic dividerLoaded,
   output logic keyAccessEnabled,
   output logic deviceSecured
);
   import flash_regs_pkg::*;

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   timing_clk_if tcIf ();

   seq_state_t seqState_r;
   seq_state_t seqState_nxt;

   logic [DIV_VALUE_W-1:0] divValue_r;
   logic divLoaded_r;
   logic [REG_W-1:0] lockStatus_r;

   logic pready_r;
   logic pslverr_r;
   logic [DATA_W-1:0] prdata_r;
   logic nvReadReq_r;
   logic [NV_ADDR_W-1:0] nvReadAddr_r;
   logic ccf_r;
   logic keyEn_r;
   logic secured_r;

   logic accessPhase;
   logic answerNow;
   logic commitNow;
   logic aligned;
   logic [IDX_W-1:0] regIdx;
   logic hitDivider;
   logic hitLock;
   logic mapped;
   logic divWrite;
   logic nvLoad;
   logic [REG_W-1:0] readValue;
   logic [REG_W-1:0] dividerView;

   // -----------------------------------------------------------------
   // timing clock generator
   // -----------------------------------------------------------------
   assign tcIf.divValue = divValue_r;
   assign tcIf.divLoaded = divLoaded_r;

   timing_clock_gen clockGen (
      .mclk(mclk),
      .reset_n(reset_n),
      .tc(tcIf.gen)
   );

   // -----------------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------------
   // the slave answers in the second access cycle so that read data and
   // pready both come from flip-flops; writes commit at the pready edge
   assign accessPhase = psel && penable;
   assign answerNow = accessPhase && !pready_r;
   assign commitNow = accessPhase && pready_r;
   assign aligned = (paddr[1:0] == 2'h0);
   assign regIdx = paddr[ADDR_W-1:2];
   assign hitDivider = aligned && (regIdx == DIVIDER_IDX);
   assign hitLock = aligned && (regIdx == LOCK_STATUS_IDX);
   assign mapped = hitDivider || hitLock;

   // accepted until the first write lands, also while the reset-time load is still busy
   assign divWrite = commitNow && pwrite && hitDivider && !divLoaded_r;

   assign dividerView = {divLoaded_r, divValue_r};

   always_comb begin
      readValue = '0;
      if (hitDivider) begin
         readValue = dividerView;
      end else if (hitLock) begin
         readValue = lockStatus_r;
      end
   end

   // -----------------------------------------------------------------
   // APB answer
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= answerNow;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end else if (answerNow) begin
         prdata_r <= pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, readValue};
         pslverr_r <= !mapped;
      end else begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // timing clock divider register
   // -----------------------------------------------------------------
   // write-once: a bad first value can only be undone by a reset
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         divValue_r <= DIV_VALUE_RESET;
      end else if (divWrite) begin
         divValue_r <= pwdata[DIV_VALUE_MSB:0];
      end
   end

   // the loaded bit is set by the write itself, never by pwdata bit 7
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         divLoaded_r <= 1'b0;
      end else if (divWrite) begin
         divLoaded_r <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // reset-time load sequencer
   // -----------------------------------------------------------------
   assign nvLoad = (seqState_r == SEQ_WAIT) && nvReadValid;

   always_comb begin
      seqState_nxt = seqState_r;
      case (seqState_r)
         SEQ_REQUEST: begin
            seqState_nxt = SEQ_WAIT;
         end
         SEQ_WAIT: begin
            if (nvReadValid) begin
               seqState_nxt = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            seqState_nxt = SEQ_RUN;
         end
         default: begin
            seqState_nxt = SEQ_REQUEST;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         seqState_r <= SEQ_REQUEST;
      end else begin
         seqState_r <= seqState_nxt;
      end
   end

   // request stands from the first edge after reset until the byte returns
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         nvReadReq_r <= 1'b0;
         nvReadAddr_r <= '0;
      end else begin
         nvReadReq_r <= (seqState_nxt == SEQ_WAIT);
         nvReadAddr_r <= NV_SECURITY_ADDR;
      end
   end

   // -----------------------------------------------------------------
   // lock status register
   // -----------------------------------------------------------------
   // secured with backdoor disabled until the load lands, so a slow
   // nonvolatile read never exposes an unsecured window
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         lockStatus_r <= LOCK_RESET;
      end else if (nvLoad) begin
         if (nvDoubleFault) begin
            lockStatus_r <= LOCK_FAULT_VALUE;
         end else begin
            lockStatus_r <= nvReadData;
         end
      end else if (seqState_r == SEQ_RUN && backdoorUnsecure) begin
         lockStatus_r[LOCK_MSB:LOCK_LSB] <= LOCK_UNSECURED;
      end
   end

   // -----------------------------------------------------------------
   // decoded security state
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         keyEn_r <= 1'b0;
         secured_r <= 1'b1;
      end else begin
         keyEn_r <= (lockStatus_r[KEY_EN_MSB:KEY_EN_LSB] == KEY_EN_ENABLED);
         secured_r <= (lockStatus_r[LOCK_MSB:LOCK_LSB] != LOCK_UNSECURED);
      end
   end

   // -----------------------------------------------------------------
   // command complete flag
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ccf_r <= 1'b0;
      end else begin
         ccf_r <= (seqState_r == SEQ_RUN) && !cmdActive;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign nvReadReq = nvReadReq_r;
   assign nvReadAddr = nvReadAddr_r;
   assign commandCompleteFlag = ccf_r;
   assign timingClock = tcIf.level;
   assign timingTick = tcIf.tick;
   assign dividerLoaded = divLoaded_r;
   assign keyAccessEnabled = keyEn_r;
   assign deviceSecured = secured_r;

endmodule // flash_clock_div_and_security_regs
`default_nettype wire

// file: testbench/flash_regs_assertions.sv
// checker: port relations of the flash divider and lock status registers
`timescale 1ns/1ps
`default_nettype none
module flash_regs_assertions (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [flash_regs_pkg::ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic nvReadReq,
   input wire logic [flash_regs_pkg::NV_ADDR_W-1:0] nvReadAddr,
   input wire logic nvReadValid,
   input wire logic [flash_regs_pkg::REG_W-1:0] nvReadData,
   input wire logic nvDoubleFault,
   input wire logic backdoorUnsecure,
   input wire logic commandCompleteFlag,
   input wire logic dividerLoaded,
   input wire logic keyAccessEnabled,
   input wire logic deviceSecured
);
   import flash_regs_pkg::*;
   logic loadDone_r;
   logic divWrite_r;
   logic [REG_W-1:0] nvSeen_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) loadDone_r <= 1'b0;
      else if (nvReadReq && nvReadValid) loadDone_r <= 1'b1;
   end
   always_ff @(posedge mclk) begin
      divWrite_r <= reset_n && psel && penable && pready && pwrite && paddr == 12'h000;
   end
   always_ff @(posedge mclk) begin
      if (nvReadValid) nvSeen_r <= nvReadData;
   end
   chk_loaded_sticky: assert property (dividerLoaded |=> dividerLoaded)
      else $error("divider loaded flag dropped");
   chk_loaded_cause: assert property ($rose(dividerLoaded) |-> divWrite_r)
      else $error("divider loaded without a write");
   chk_write_loads: assert property (divWrite_r |-> dividerLoaded)
      else $error("divider write not taken");
   chk_nv_address: assert property (nvReadReq |-> nvReadAddr == NV_SECURITY_ADDR)
      else $error("wrong security byte address");
   chk_ccf_held: assert property (nvReadReq |-> !commandCompleteFlag)
      else $error("command complete during load");
   chk_fault_locks: assert property (nvReadReq && nvReadValid && nvDoubleFault |-> ##2 (deviceSecured && !keyAccessEnabled))
      else $error("fault load not secured");
   chk_key_decode: assert property (nvReadReq && nvReadValid && !nvDoubleFault |-> ##2 keyAccessEnabled == (nvSeen_r[7:6] == KEY_EN_ENABLED))
      else $error("key enable decode wrong");
   chk_lock_decode: assert property (nvReadReq && nvReadValid && !nvDoubleFault |-> ##2 deviceSecured == (nvSeen_r[1:0] != LOCK_UNSECURED))
      else $error("lock state decode wrong");
   chk_backdoor_opens: assert property (loadDone_r && backdoorUnsecure |-> ##2 !deviceSecured)
      else $error("backdoor unsecure not applied");
endmodule // flash_regs_assertions
bind flash_clock_div_and_security_regs flash_regs_assertions i_flash_regs_assertions (
   .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pready(pready), .nvReadReq(nvReadReq), .nvReadAddr(nvReadAddr),
   .nvReadValid(nvReadValid), .nvReadData(nvReadData), .nvDoubleFault(nvDoubleFault),
   .backdoorUnsecure(backdoorUnsecure), .commandCompleteFlag(commandCompleteFlag),
   .dividerLoaded(dividerLoaded), .keyAccessEnabled(keyAccessEnabled),
   .deviceSecured(deviceSecured));
`default_nettype wire

// file: testbench/flash_clock_div_and_security_regs_tb.sv
// testbench: divider and lock status registers driven over apb
`timescale 1ns/1ps
`default_nettype none
module flash_clock_div_and_security_regs_tb;
   import flash_regs_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, nvReadReq, timingTick, timingClock, dividerLoaded, keyAccessEnabled;
   logic deviceSecured, commandCompleteFlag, err;
   logic [NV_ADDR_W-1:0] nvReadAddr;
   logic nvReadValid = 1'b0, nvDoubleFault = 1'b0, cmdActive = 1'b0, backdoorUnsecure = 1'b0;
   logic [REG_W-1:0] nvReadData = '0;
   int mismatches = 0, cmp_count = 0;
   always #2.5 mclk = ~mclk;
   flash_clock_div_and_security_regs i_flash_clock_div_and_security_regs (
      .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nvReadReq(nvReadReq), .nvReadAddr(nvReadAddr), .nvReadValid(nvReadValid),
      .nvReadData(nvReadData), .nvDoubleFault(nvDoubleFault), .cmdActive(cmdActive),
      .backdoorUnsecure(backdoorUnsecure), .commandCompleteFlag(commandCompleteFlag),
      .timingClock(timingClock), .timingTick(timingTick), .dividerLoaded(dividerLoaded),
      .keyAccessEnabled(keyAccessEnabled), .deviceSecured(deviceSecured));
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one transfer; a trailing edge keeps back-to-back calls from double driving psel
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic start();
      int n = 0;
      reset_n <= 1'b0;
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      while (nvReadReq !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      cmp32("nv address", 32'(NV_SECURITY_ADDR), 32'(nvReadAddr));
      cmp32("ccf in load", 0, 32'(commandCompleteFlag));
   endtask
   task automatic finish_load(input logic [7:0] d, input logic f);
      nvReadValid <= 1'b1;
      nvReadData <= d;
      nvDoubleFault <= f;
      @(posedge mclk);
      nvReadValid <= 1'b0;
      nvReadData <= ~d;
      repeat (2) @(posedge mclk);
   endtask
   task automatic s_divider();
      int n = 0;
      logic lvl;
      start();
      apb(1'b0, 12'h000, '0);
      cmp32("divider reset", 0, rd);
      apb(1'b1, 12'h000, 32'h0000_002F);
      cmp32("early loaded", 1, 32'(dividerLoaded));
      finish_load(8'hFF, 1'b0);
      cmp32("ccf after load", 1, 32'(commandCompleteFlag));
      apb(1'b1, 12'h000, 32'h0000_0010);
      apb(1'b0, 12'h000, '0);
      cmp32("divider once", 32'h0000_00AF, rd);
      while (timingTick !== 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      @(posedge mclk);
      n = 1;
      while (timingTick !== 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      cmp32("tick period", 48, n);
      lvl = timingClock;
      repeat (48) @(posedge mclk);
      cmp32("clock toggles", 32'(!lvl), 32'(timingClock));
   endtask
   task automatic s_decode();
      logic [7:0] code;
      for (int i = 0; i < 4; i++) begin
         code = {i[1:0], 4'hF, i[1:0]};
         start();
         finish_load(code, 1'b0);
         cmp32("key enable", 32'(i == 2), 32'(keyAccessEnabled));
         cmp32("secured", 32'(i != 2), 32'(deviceSecured));
         apb(1'b0, 12'h004, '0);
         cmp32("lock read", {24'h0, code}, rd);
      end
   endtask
   task automatic s_lock();
      start();
      finish_load(8'h00, 1'b1);
      apb(1'b0, 12'h004, '0);
      cmp32("fault load", 32'h0000_00FF, rd);
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b0, 12'h004, '0);
      cmp32("lock write", 32'h0000_00FF, rd);
      apb(1'b0, 12'h008, '0);
      cmp32("unmapped err", 1, 32'(err));
      backdoorUnsecure <= 1'b1;
      @(posedge mclk);
      backdoorUnsecure <= 1'b0;
      repeat (2) @(posedge mclk);
      cmp32("backdoor secured", 0, 32'(deviceSecured));
      apb(1'b0, 12'h004, '0);
      cmp32("backdoor lock", 32'h0000_00FE, rd);
   endtask
   initial begin
      s_divider();
      s_decode();
      s_lock();
      summarize();
   end
   initial begin
      #100000;
      mismatches++;
      summarize();
   end
endmodule // flash_clock_div_and_security_regs_tb
`default_nettype wire
